// ==== crf_pkg.sv ====
// Package of constants for the core register, flag and return stack block.
package crf_pkg;
    // ========================================================================
    // Data-space addresses of the mapped registers.
    localparam logic [7:0]  ADDR_POINTER_ONE  = 8'h80;
    localparam logic [7:0]  ADDR_POINTER_TWO  = 8'h81;
    localparam logic [7:0]  ADDR_SHORT_ONE    = 8'h82;
    localparam logic [7:0]  ADDR_SHORT_SECOND = 8'h83;
    localparam logic [7:0]  ADDR_ACCUMULATOR  = 8'hFF;
    // ========================================================================
    // Reset values and widths.
    localparam logic [7:0]  RST_DATA_REG      = 8'h00;
    localparam logic [11:0] RST_PC            = 12'h000;
    localparam int          PC_W              = 12;
    localparam int          STACK_DEPTH       = 6;
    localparam logic [2:0]  STACK_MAX         = 3'h6;
    // ========================================================================
    // Flag contexts, one-hot.
    typedef enum logic [2:0]
    {
        CRF_CTX_NORMAL = 3'b001,
        CRF_CTX_INTR   = 3'b010,
        CRF_CTX_NMI    = 3'b100
    } crf_ctx_e;
    // Program counter update sources, one-hot.
    typedef enum logic [5:0]
    {
        CRF_PC_HOLD   = 6'b000001,
        CRF_PC_INCR   = 6'b000010,
        CRF_PC_BRANCH = 6'b000100,
        CRF_PC_JUMP   = 6'b001000,
        CRF_PC_CALL   = 6'b010000,
        CRF_PC_RETURN = 6'b100000
    } crf_pc_e;
endpackage

// ==== crf_return_stack.sv ====
// Six-level return stack for the program counter, with context history.
`timescale 1ns/1ps
module crf_return_stack
(
    // Clock, reset and enable.
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Push and pop controls.
    input  wire logic                 push_i,
    input  wire logic                 pop_i,
    input  wire logic [11:0]          push_pc_i,
    input  wire logic [2:0]           push_ctx_i,
    // Top of stack and state.
    output logic      [11:0]          top_pc_o,
    output logic      [2:0]           top_ctx_o,
    output logic                      empty_o,
    output logic      [2:0]           level_o
);
    // ========================================================================
    // Storage levels; level 0 is the first level.
    logic [11:0] pc_lvl_ff  [crf_pkg::STACK_DEPTH];
    logic [2:0]  ctx_lvl_ff [crf_pkg::STACK_DEPTH];
    logic [2:0]  level_ff;

    // Each level shifts deeper on push and up on pop.
    genvar g;
    generate
        for (g = 0; g < crf_pkg::STACK_DEPTH; g = g + 1)
        begin : g_lvl
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pc_lvl_ff[g]  <= crf_pkg::RST_PC;
                    ctx_lvl_ff[g] <= 3'h4;
                end
                else if (ce_i && push_i)
                begin
                    pc_lvl_ff[g]  <= (g == 0) ? push_pc_i : pc_lvl_ff[(g == 0) ? 0 : g - 1]; // [RQ18]
                    ctx_lvl_ff[g] <= (g == 0) ? push_ctx_i : ctx_lvl_ff[(g == 0) ? 0 : g - 1]; // [RQ23]
                end
                else if (ce_i && pop_i && level_ff != 3'h0)
                begin
                    // The deepest level keeps its value; nothing fills it from below.
                    pc_lvl_ff[g]  <= pc_lvl_ff[(g == crf_pkg::STACK_DEPTH - 1) ? g : g + 1]; // [RQ19]
                    ctx_lvl_ff[g] <= ctx_lvl_ff[(g == crf_pkg::STACK_DEPTH - 1) ? g : g + 1];
                end
            end
        end
    endgenerate

    // Fill level saturates at six and at zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            level_ff <= 3'h0;
        else if (ce_i && push_i && level_ff != crf_pkg::STACK_MAX)
            level_ff <= level_ff + 3'h1; // [RQ20]
        else if (ce_i && pop_i && !push_i && level_ff != 3'h0)
            level_ff <= level_ff - 3'h1; // [RQ21]
    end

    assign top_pc_o  = pc_lvl_ff[0];
    assign top_ctx_o = ctx_lvl_ff[0];
    assign empty_o   = (level_ff == 3'h0);
    assign level_o   = level_ff;
endmodule

// ==== crf_core_regs.sv ====
// Programmer-visible core registers: data-space registers, counter and flag pairs.
`timescale 1ns/1ps
// How it works
// [RQ1] Accumulator is 8 bits, also a data-space location at FFh.
// [RQ2] First pointer at 80h, second at 81h, data-space readable and writable.
// [RQ3] Two short-direct holding registers live at 82h and 83h.
// [RQ4] Indirect mode uses a selected pointer as the operand address.
// [RQ5] Program counter is 12 bits, covering 4096 program bytes.
// [RQ6] Larger program space uses a separate bank register; counter stays 12 bits.
// [RQ7] Normal fetch increments the program counter by one.
// [RQ8] Relative branch loads counter plus signed offset.
// [RQ9] Jump, call, interrupt vector and reset vector load the counter.
// [RQ10] Three carry/zero pairs: normal, interrupt and non-maskable.
// [RQ11] Entry switches to the context's pair; interrupt exit restores previous.
// [RQ12] Context switch never clears any flag pair.
// [RQ13] Flag reads and writes touch only the active context's pair.
// [RQ14] Carry follows arithmetic carry or borrow, bit tests, and feeds rotate-left.
// [RQ15] Zero is set when the last result equals zero.
// [RQ16] Reset enters non-maskable context and uses its flag pair.
// [RQ17] Six-level 12-bit hardware return stack outside data space.
// [RQ18] Call or entry shifts levels deeper and pushes the counter.
// [RQ19] Return pops level one into the counter and shifts levels up.
// [RQ20] Beyond six nestings the stack stays deepest, oldest address lost.
// [RQ21] Return on empty stack keeps position and continues sequentially.
// [RQ22] Only the counter is stacked, never data-space registers.
// [RQ23] Context history is stacked so nested exits restore the right pair.
module crf_core_regs
(
    // Clock, reset and enable.
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    // Data-space bus.
    input  wire logic [7:0]           ds_addr_i,
    input  wire logic                 ds_wr_i,
    input  wire logic [7:0]           ds_wdata_i,
    output logic      [7:0]           ds_rdata_o,
    output logic                      ds_hit_o,
    // Indirect addressing.
    input  wire logic                 ind_sel_i,
    output logic      [7:0]           ind_addr_o,
    // Accumulator load from the arithmetic unit.
    input  wire logic                 acc_load_i,
    input  wire logic [7:0]           acc_data_i,
    output logic      [7:0]           acc_o,
    // Program counter control.
    input  wire logic [5:0]           pc_op_i,
    input  wire logic [11:0]          pc_target_i,
    input  wire logic [7:0]           branch_offset_i,
    input  wire logic [11:0]          reset_vector_i,
    input  wire logic                 intr_entry_i,
    input  wire logic                 nmi_entry_i,
    input  wire logic [11:0]          intr_vector_i,
    input  wire logic                 intr_exit_i,
    output logic      [11:0]          program_counter_o,
    // Flag updates.
    input  wire logic                 arith_upd_i,
    input  wire logic                 arith_carry_i,
    input  wire logic [7:0]           result_i,
    input  wire logic                 logic_upd_i,
    input  wire logic                 bit_test_i,
    input  wire logic                 tested_bit_i,
    output logic                      carry_o,
    output logic                      zero_o,
    output logic                      rotate_in_o,
    // Context and stack state.
    output logic      [2:0]           context_o,
    output logic      [2:0]           stack_level_o,
    output logic                      stack_empty_o
);
    // ========================================================================
    // Registers.
    logic [7:0]  accumulator_ff;
    logic [7:0]  pointer_one_ff;
    logic [7:0]  pointer_two_ff;
    logic [7:0]  short_direct_one_ff;
    logic [7:0]  short_direct_second_ff;
    logic [11:0] pc_ff;
    logic [2:0]  ctx_ff;
    logic [1:0]  flags_ff [3];
    logic [7:0]  rdata_ff;
    logic        hit_ff;
    logic        started_ff;

    // ========================================================================
    // Address decode.
    wire hit_acc  = (ds_addr_i == crf_pkg::ADDR_ACCUMULATOR); // [RQ1]
    wire hit_p1   = (ds_addr_i == crf_pkg::ADDR_POINTER_ONE); // [RQ2]
    wire hit_p2   = (ds_addr_i == crf_pkg::ADDR_POINTER_TWO); // [RQ2]
    wire hit_v    = (ds_addr_i == crf_pkg::ADDR_SHORT_ONE); // [RQ3]
    wire hit_w    = (ds_addr_i == crf_pkg::ADDR_SHORT_SECOND); // [RQ3]
    wire any_hit  = hit_acc | hit_p1 | hit_p2 | hit_v | hit_w;
    wire [7:0] rd_mux = hit_acc ? accumulator_ff :
                        hit_p1  ? pointer_one_ff :
                        hit_p2  ? pointer_two_ff :
                        hit_v   ? short_direct_one_ff :
                        hit_w   ? short_direct_second_ff : 8'h00;

    // Indirect operand address comes straight from the chosen pointer.
    assign ind_addr_o = ind_sel_i ? pointer_two_ff : pointer_one_ff; // [RQ4]

    // ========================================================================
    // Accumulator: an arithmetic load wins over a data-space write in one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            accumulator_ff <= crf_pkg::RST_DATA_REG;
        else if (ce_i && acc_load_i)
            accumulator_ff <= acc_data_i; // [RQ1]
        else if (ce_i && ds_wr_i && hit_acc)
            accumulator_ff <= ds_wdata_i; // [RQ1]
    end

    // Pointer and short-direct registers written over data space.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pointer_one_ff         <= crf_pkg::RST_DATA_REG;
            pointer_two_ff         <= crf_pkg::RST_DATA_REG;
            short_direct_one_ff    <= crf_pkg::RST_DATA_REG;
            short_direct_second_ff <= crf_pkg::RST_DATA_REG;
        end
        else if (ce_i && ds_wr_i)
        begin
            if (hit_p1)
                pointer_one_ff <= ds_wdata_i; // [RQ2]
            if (hit_p2)
                pointer_two_ff <= ds_wdata_i; // [RQ2]
            if (hit_v)
                short_direct_one_ff <= ds_wdata_i; // [RQ3]
            if (hit_w)
                short_direct_second_ff <= ds_wdata_i; // [RQ3]
        end
    end

    // Read data is registered so it lands one cycle after the address.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= 8'h00;
            hit_ff   <= 1'b0;
        end
        else if (ce_i)
        begin
            rdata_ff <= rd_mux;
            hit_ff   <= any_hit;
        end
    end
    assign ds_rdata_o = rdata_ff;
    assign ds_hit_o   = hit_ff;

    // ========================================================================
    // Return stack. Only the counter and the flag context go in, no data registers.
    logic [11:0] top_pc;
    logic [2:0]  top_ctx;
    logic        stk_empty;
    wire         is_call   = (pc_op_i == crf_pkg::CRF_PC_CALL);
    wire         is_return = (pc_op_i == crf_pkg::CRF_PC_RETURN);
    wire         entry     = intr_entry_i | nmi_entry_i;
    wire         do_push   = entry | (is_call & !intr_exit_i); // [RQ22]
    wire         do_pop    = (is_return | intr_exit_i) & !do_push;
    // Interrupt entry stacks the counter itself; an entry with a call in the same cycle stacks the counter plus one.
    wire [11:0]  push_pc   = is_call ? (pc_ff + 12'h001) : pc_ff;

    crf_return_stack u_stack
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .push_i     (do_push), // [RQ17]
        .pop_i      (do_pop),
        .push_pc_i  (push_pc),
        .push_ctx_i (ctx_ff), // [RQ23]
        .top_pc_o   (top_pc),
        .top_ctx_o  (top_ctx),
        .empty_o    (stk_empty),
        .level_o    (stack_level_o)
    );
    assign stack_empty_o = stk_empty;

    // ========================================================================
    // Program counter next value. The offset is sign-extended to counter width.
    wire [11:0] branch_sum = pc_ff + {{4{branch_offset_i[7]}}, branch_offset_i}; // [RQ8]
    logic [11:0] nxt_pc;
    always_comb
    begin
        nxt_pc = pc_ff;
        if (entry)
            nxt_pc = intr_vector_i; // [RQ9]
        else if (intr_exit_i)
            nxt_pc = stk_empty ? pc_ff + 12'h001 : top_pc; // [RQ21]
        else
        begin
            case (pc_op_i)
                crf_pkg::CRF_PC_HOLD:   nxt_pc = pc_ff;
                crf_pkg::CRF_PC_INCR:   nxt_pc = pc_ff + 12'h001; // [RQ7]
                crf_pkg::CRF_PC_BRANCH: nxt_pc = branch_sum; // [RQ8]
                crf_pkg::CRF_PC_JUMP:   nxt_pc = pc_target_i; // [RQ9]
                crf_pkg::CRF_PC_CALL:   nxt_pc = pc_target_i; // [RQ9]
                crf_pkg::CRF_PC_RETURN: nxt_pc = stk_empty ? pc_ff + 12'h001 : top_pc; // [RQ19] [RQ21]
                default:                nxt_pc = pc_ff;
            endcase
        end
    end

    // The counter wraps in 12 bits; banked program space is outside this block.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_ff      <= crf_pkg::RST_PC;
            started_ff <= 1'b0;
        end
        else if (ce_i && !started_ff)
        begin
            // The vector is a port, so it is loaded on the first enabled edge after release.
            pc_ff      <= reset_vector_i; // [RQ9]
            started_ff <= 1'b1;
        end
        else if (ce_i)
            pc_ff <= nxt_pc; // [RQ5] [RQ6]
    end
    assign program_counter_o = pc_ff;

    // ========================================================================
    // Active flag context.
    logic [2:0] nxt_ctx;
    always_comb
    begin
        nxt_ctx = ctx_ff;
        if (nmi_entry_i)
            nxt_ctx = crf_pkg::CRF_CTX_NMI; // [RQ11]
        else if (intr_entry_i)
            nxt_ctx = crf_pkg::CRF_CTX_INTR; // [RQ11]
        else if (intr_exit_i && !stk_empty)
            nxt_ctx = top_ctx; // [RQ11] [RQ23]
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctx_ff <= crf_pkg::CRF_CTX_NMI; // [RQ16]
        else if (ce_i)
            ctx_ff <= nxt_ctx;
    end
    assign context_o = ctx_ff;

    // ========================================================================
    // Flag pairs, bit 1 carry and bit 0 zero. Only the active pair updates.
    wire [1:0] ctx_idx = ctx_ff[2] ? 2'd2 : ctx_ff[1] ? 2'd1 : 2'd0; // [RQ13]
    wire       res_zero = (result_i == 8'h00);

    genvar f;
    generate
        for (f = 0; f < 3; f = f + 1)
        begin : g_flags
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    flags_ff[f] <= 2'b00;
                else if (ce_i && ctx_idx == f) // [RQ10] [RQ12] [RQ13]
                begin
                    if (arith_upd_i)
                        flags_ff[f] <= {arith_carry_i, res_zero}; // [RQ14] [RQ15]
                    else if (bit_test_i)
                        flags_ff[f][1] <= tested_bit_i; // [RQ14]
                    else if (logic_upd_i)
                        flags_ff[f][0] <= res_zero; // [RQ15]
                end
            end
        end
    endgenerate

    assign carry_o     = flags_ff[ctx_idx][1]; // [RQ13]
    assign zero_o      = flags_ff[ctx_idx][0];
    assign rotate_in_o = flags_ff[ctx_idx][1]; // [RQ14]
    assign acc_o       = accumulator_ff;
endmodule

// ==== crf_ds_mem.sv ====
// Behavioural data-space RAM standing beside the core registers.
`timescale 1ns/1ps
module crf_ds_mem
(
    // Clock and bus.
    input  wire logic       clk_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    // Registered read data.
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [0:127];
    // RAM answers 00h to 7Fh only; off it the line toggles so no stale byte passes for data.
    always_ff @(posedge clk_i)
    begin
        if (ce_i && !addr_i[7] && wr_i)
            mem[addr_i[6:0]] <= wdata_i;
        if (ce_i && !addr_i[7])
            rdata_o <= mem[addr_i[6:0]];
        else
            rdata_o <= ~rdata_o;
    end
endmodule

// ==== crf_core_regs_props.sv ====
// Port checker for the core register, flag and return stack block.
`timescale 1ns/1ps
module crf_core_regs_chk
(
    // Watched ports.
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic [7:0]  ds_addr_i,
    input wire logic        ds_wr_i,
    input wire logic [7:0]  ds_wdata_i,
    input wire logic        ind_sel_i,
    input wire logic        acc_load_i,
    input wire logic [5:0]  pc_op_i,
    input wire logic [11:0] pc_target_i,
    input wire logic [7:0]  branch_offset_i,
    input wire logic        intr_entry_i,
    input wire logic        nmi_entry_i,
    input wire logic        intr_exit_i,
    input wire logic        arith_upd_i,
    input wire logic        arith_carry_i,
    input wire logic [7:0]  result_i,
    input wire logic [7:0]  ds_rdata_o,
    input wire logic        ds_hit_o,
    input wire logic [7:0]  ind_addr_o,
    input wire logic [7:0]  acc_o,
    input wire logic [11:0] program_counter_o,
    input wire logic        carry_o,
    input wire logic        zero_o,
    input wire logic [2:0]  context_o,
    input wire logic [2:0]  stack_level_o,
    input wire logic        stack_empty_o
);
    // ========================================================================
    // Helpers: the first enabled edge after reset loads the vector, so skip it.
    logic started_ff;
    wire  quiet  = started_ff && ce_i && !intr_entry_i && !nmi_entry_i && !intr_exit_i;
    wire  mapped = (ds_addr_i[7:2] == 6'h20) || (ds_addr_i == 8'hFF);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            started_ff <= 1'b0;
        else if (ce_i)
            started_ff <= 1'b1;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ========================================================================
    // Assertions.
    AST_ACC_WR: assert property (ce_i && ds_wr_i && !acc_load_i && ds_addr_i == 8'hFF
        |=> acc_o == $past(ds_wdata_i)) else $error("accumulator write lost");
    AST_IND_READ: assert property (ce_i && !ds_wr_i && ds_addr_i == {7'h40, ind_sel_i}
        |=> ds_hit_o && ds_rdata_o == $past(ind_addr_o)) else $error("pointer readback wrong");
    AST_UNMAPPED: assert property (ce_i && !mapped |=> !ds_hit_o && ds_rdata_o == 8'h00)
        else $error("unmapped address answered");
    AST_PC_INCR: assert property (quiet && pc_op_i == 6'h02
        |=> program_counter_o == $past(program_counter_o) + 12'h001) else $error("counter increment wrong");
    AST_PC_BRANCH: assert property (quiet && pc_op_i == 6'h04 |=> program_counter_o ==
        $past(program_counter_o) + {{4{$past(branch_offset_i[7])}}, $past(branch_offset_i)})
        else $error("branch sum wrong");
    AST_PC_JUMP: assert property (quiet && (pc_op_i == 6'h08 || pc_op_i == 6'h10)
        |=> program_counter_o == $past(pc_target_i)) else $error("jump target not loaded");
    AST_RST_CTX: assert property (!rst_i && $past(rst_i)
        |-> context_o == 3'b100 && stack_empty_o) else $error("reset context wrong");
    AST_NMI_ENTRY: assert property (ce_i && nmi_entry_i |=> context_o == 3'b100 &&
        stack_level_o == (($past(stack_level_o) == 3'h6) ? 3'h6 : $past(stack_level_o) + 3'h1))
        else $error("nmi entry wrong");
    AST_FLAGS: assert property (ce_i && arith_upd_i && !intr_entry_i && !nmi_entry_i && !intr_exit_i
        |=> carry_o == $past(arith_carry_i) && zero_o == ($past(result_i) == 8'h00))
        else $error("arithmetic flags wrong");
    AST_POP: assert property (quiet && !stack_empty_o && pc_op_i == 6'h20
        |=> stack_level_o == $past(stack_level_o) - 3'h1) else $error("pop level wrong");
    AST_RET_EMPTY: assert property (quiet && stack_empty_o && pc_op_i == 6'h20
        |=> stack_empty_o && program_counter_o == $past(program_counter_o) + 12'h001)
        else $error("empty return wrong");
    // Main scenarios reached.
    cover property (ce_i && nmi_entry_i && context_o == 3'b010);
    cover property (ce_i && pc_op_i == 6'h10 && stack_level_o == 3'h6);
    cover property (ce_i && intr_exit_i && !stack_empty_o);
endmodule
bind crf_core_regs crf_core_regs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ds_addr_i(ds_addr_i),
    .ds_wr_i(ds_wr_i), .ds_wdata_i(ds_wdata_i), .ind_sel_i(ind_sel_i), .acc_load_i(acc_load_i), .pc_op_i(pc_op_i),
    .pc_target_i(pc_target_i), .branch_offset_i(branch_offset_i), .intr_entry_i(intr_entry_i),
    .nmi_entry_i(nmi_entry_i), .intr_exit_i(intr_exit_i), .arith_upd_i(arith_upd_i), .arith_carry_i(arith_carry_i),
    .result_i(result_i), .ds_rdata_o(ds_rdata_o), .ds_hit_o(ds_hit_o), .ind_addr_o(ind_addr_o), .acc_o(acc_o),
    .program_counter_o(program_counter_o), .carry_o(carry_o), .zero_o(zero_o), .context_o(context_o),
    .stack_level_o(stack_level_o), .stack_empty_o(stack_empty_o));

// ==== cpu_regs_flags_stack_tb.sv ====
// Self-checking testbench for the core register, flag and return stack block.
`timescale 1ns/1ps
module cpu_regs_flags_stack_tb;
    localparam logic [11:0] RST_VEC = 12'h100;
    localparam logic [11:0] IVEC    = 12'h0F0;
    localparam logic [7:0]  ADDRS [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
    logic [7:0]  ds_addr_i = 8'h00, ds_wdata_i = 8'h00, acc_data_i = 8'h00, branch_offset_i = 8'h00;
    logic [7:0]  result_i = 8'h00, ds_rdata_o, ind_addr_o, acc_o, mem_rdata;
    logic [11:0] pc_target_i = 12'h000, program_counter_o;
    logic [5:0]  pc_op_i = 6'h01;
    logic [2:0]  context_o, stack_level_o;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, ds_wr_i = 1'b0, ind_sel_i = 1'b0, acc_load_i = 1'b0;
    logic        intr_entry_i = 1'b0, nmi_entry_i = 1'b0, intr_exit_i = 1'b0, arith_upd_i = 1'b0;
    logic        arith_carry_i = 1'b0, logic_upd_i = 1'b0, bit_test_i = 1'b0, tested_bit_i = 1'b0;
    logic        ds_hit_o, carry_o, zero_o, rotate_in_o, stack_empty_o;
    int          err_count = 0;
    int          num_checks = 0;
    int          j;
    always #5 clk_i = ~clk_i;
    // ========================================================================
    // Design and the data-space RAM beside it.
    crf_core_regs i_crf_core_regs (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ds_addr_i(ds_addr_i),
        .ds_wr_i(ds_wr_i), .ds_wdata_i(ds_wdata_i), .ds_rdata_o(ds_rdata_o), .ds_hit_o(ds_hit_o),
        .ind_sel_i(ind_sel_i), .ind_addr_o(ind_addr_o), .acc_load_i(acc_load_i), .acc_data_i(acc_data_i),
        .acc_o(acc_o), .pc_op_i(pc_op_i), .pc_target_i(pc_target_i), .branch_offset_i(branch_offset_i),
        .reset_vector_i(RST_VEC), .intr_entry_i(intr_entry_i), .nmi_entry_i(nmi_entry_i), .intr_vector_i(IVEC),
        .intr_exit_i(intr_exit_i), .program_counter_o(program_counter_o), .arith_upd_i(arith_upd_i),
        .arith_carry_i(arith_carry_i), .result_i(result_i), .logic_upd_i(logic_upd_i), .bit_test_i(bit_test_i),
        .tested_bit_i(tested_bit_i), .carry_o(carry_o), .zero_o(zero_o), .rotate_in_o(rotate_in_o),
        .context_o(context_o), .stack_level_o(stack_level_o), .stack_empty_o(stack_empty_o));
    crf_ds_mem i_crf_ds_mem (.clk_i(clk_i), .ce_i(ce_i), .addr_i(ds_addr_i), .wr_i(ds_wr_i),
        .wdata_i(ds_wdata_i), .rdata_o(mem_rdata));
    // ========================================================================
    // Compare, verdict and access tasks.
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Bus access: the core takes it at the following edge and registers its answer at that same edge.
    task automatic ds(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        ds_addr_i <= a;
        ds_wr_i <= w;
        ds_wdata_i <= d;
        @(posedge clk_i);
        ds_wr_i <= 1'b0;
        #1;
    endtask
    // One counter or context request; events are {nmi entry, interrupt entry, interrupt exit}.
    task automatic op(input logic [5:0] p, input logic [11:0] t, input logic [2:0] ev);
        @(posedge clk_i);
        pc_op_i <= p;
        pc_target_i <= t;
        branch_offset_i <= t[7:0];
        {nmi_entry_i, intr_entry_i, intr_exit_i} <= ev;
        @(posedge clk_i);
        pc_op_i <= 6'h01;
        {nmi_entry_i, intr_entry_i, intr_exit_i} <= 3'h0;
        #1;
    endtask
    // One flag update; kinds are {arithmetic, bit test, logical}.
    task automatic flg(input logic [2:0] k, input logic c, input logic [7:0] r);
        @(posedge clk_i);
        {arith_upd_i, bit_test_i, logic_upd_i} <= k;
        arith_carry_i <= c;
        tested_bit_i <= c;
        result_i <= r;
        @(posedge clk_i);
        {arith_upd_i, bit_test_i, logic_upd_i} <= 3'h0;
        #1;
    endtask
    task automatic st(input logic [2:0] c, input logic [1:0] f, input logic [11:0] p);
        chk("context", {9'h000, c}, {9'h000, context_o});
        chk("flags", {9'h000, f[1], f}, {9'h000, rotate_in_o, carry_o, zero_o});
        chk("pc", p, program_counter_o);
    endtask
    // A hang ends the run as a mismatch.
    initial
    begin
        #900000;
        err_count++;
        complete_run;
    end
    // ========================================================================
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        st(3'b100, 2'b00, RST_VEC);
        for (j = 0; j < 5; j++)
            ds(ADDRS[j], 1'b1, ADDRS[j] ^ 8'h5A);
        for (j = 0; j < 5; j++)
        begin
            ds(ADDRS[j], 1'b0, 8'h00);
            chk("rdata", {4'h1, ADDRS[j] ^ 8'h5A}, {3'h0, ds_hit_o, ds_rdata_o});
        end
        chk("ind0", 12'h0DA, {4'h0, ind_addr_o});
        @(posedge clk_i);
        ind_sel_i <= 1'b1;
        acc_load_i <= 1'b1;
        acc_data_i <= 8'h77;
        @(posedge clk_i);
        acc_load_i <= 1'b0;
        #1;
        chk("ind1", 12'h0DB, {4'h0, ind_addr_o});
        chk("acc", 12'h077, {4'h0, acc_o});
        // Bytes below 80h belong to the RAM; the core stays silent there.
        ds(8'h40, 1'b1, 8'h3C);
        ds(8'h40, 1'b0, 8'h00);
        chk("unmapped", 12'h000, {3'h0, ds_hit_o, ds_rdata_o});
        chk("ram", 12'h03C, {4'h0, mem_rdata});
        op(6'h08, 12'hFFF, 3'h0);
        chk("jump", 12'hFFF, program_counter_o);
        op(6'h02, 12'h000, 3'h0);
        chk("wrap", 12'h000, program_counter_o);
        op(6'h04, 12'h0FE, 3'h0);
        chk("branch", 12'hFFE, program_counter_o);
        op(6'h08, 12'h200, 3'h0);
        // Seven nested calls overflow the six levels; the oldest return is lost.
        for (j = 0; j < 7; j++)
        begin
            op(6'h10, 12'h300 + 12'(j * 16), 3'h0);
            chk("level", (j < 6) ? 12'(j + 1) : 12'h006, {9'h000, stack_level_o});
        end
        for (j = 0; j < 7; j++)
        begin
            op(6'h20, 12'h000, 3'h0);
            chk("ret", (j < 6) ? 12'h351 - 12'(j * 16) : 12'h302, program_counter_o);
        end
        chk("empty", 12'h001, {11'h000, stack_empty_o});
        chk("acc kept", 12'h077, {4'h0, acc_o});
        flg(3'b100, 1'b1, 8'h05);
        flg(3'b001, 1'b0, 8'h00);
        st(3'b100, 2'b11, 12'h302);
        op(6'h01, 12'h000, 3'b010);
        st(3'b010, 2'b00, IVEC);
        flg(3'b010, 1'b1, 8'h00);
        st(3'b010, 2'b10, IVEC);
        op(6'h01, 12'h000, 3'b100);
        st(3'b100, 2'b11, IVEC);
        op(6'h01, 12'h000, 3'b001);
        st(3'b010, 2'b10, IVEC);
        op(6'h01, 12'h000, 3'b001);
        st(3'b100, 2'b11, 12'h302);
        // Clock enable low must freeze counter, context and flags despite a request.
        @(posedge clk_i);
        ce_i <= 1'b0;
        op(6'h02, 12'h000, 3'b010);
        st(3'b100, 2'b11, 12'h302);
        @(posedge clk_i);
        ce_i <= 1'b1;
        complete_run;
    end
endmodule
